// File: verilog/gp_port_pkg.sv
// Purpose: shared constants for the general-purpose pin port
// Assumes: 20 MHz mclk, AHB-Lite register access, 32-bit data
// Notes:   register offsets are byte addresses of aligned words
`default_nettype none

package gp_port_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 50;      // 20 MHz master clock
    localparam int unsigned TRI_SETTLE_NS = 1000;    // least pull settle time
    // least time, so round up
    localparam int unsigned TRI_SETTLE_CYC =
        (TRI_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // register offsets (byte addresses)
    localparam logic [7:0] OFF_LVL_FIRST  = 8'h00;  // gp_level_ctrl_first
    localparam logic [7:0] OFF_LVL_SECOND = 8'h04;  // gp_level_ctrl_second
    localparam logic [7:0] OFF_CHAN_SEL   = 8'h08;  // channel_port_select
    localparam logic [7:0] OFF_TRI_STAT   = 8'h0c;  // strap and hold status
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h10;  // sticky change flags
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;  // interrupt mask

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int unsigned LVL_OUT2     = 2;  // first reg: bits 7..2 = general_outputs_two_to_seven
    localparam int unsigned LVL_GENERAL_OUTPUT_TEN    = 0;  // second reg: output ten level
    localparam int unsigned SEL_COL5     = 5;  // second reg: column five pin is output
    localparam int unsigned SEL_COL6     = 6;  // second reg: column six pin is output
    localparam int unsigned SEL_TRI0     = 7;  // second reg: shared tenth pin is output
    localparam int unsigned CHAN_SEL_LSB = 5;  // channel_port_select field [6:5]

    ////////////////////////////////////////////////////////////////////////
    // reset values and encodings
    localparam logic [7:0] LVL_FIRST_RST  = 8'hfc;  // all levels high
    localparam logic [7:0] LVL_SECOND_RST = 8'h01;  // level high, pins as inputs
    localparam logic [1:0] CHAN_SEL_GPO   = 2'h1;   // pins act as outputs two..five
    localparam logic [1:0] TRI_GND        = 2'h0;
    localparam logic [1:0] TRI_VCC        = 2'h1;
    localparam logic [1:0] TRI_OPEN       = 2'h2;

    // pin level with pull-up applied and with pull-down applied
    function automatic logic [1:0] tri_code(input logic up, input logic dn);
        if (up && dn) begin
            tri_code = TRI_VCC;
        end else if (!up && !dn) begin
            tri_code = TRI_GND;
        end else begin
            tri_code = TRI_OPEN;  // followed the pulls: nothing attached
        end
    endfunction

endpackage : gp_port_pkg

`default_nettype wire

// File: verilog/tri_level_sense.sv
// Purpose: three-level pin detector using alternating weak pulls
// Assumes: pin settles within DIV cycles after a pull change
// Notes:   code holds its last value while disabled
`default_nettype none

module tri_level_sense import gp_port_pkg::*; #(
    parameter int unsigned DIV = TRI_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // control
    input  wire logic       enable,
    // pin side
    input  wire logic       pin_i,
    output var  logic       pull_up_en,
    output var  logic       pull_dn_en,
    // result
    output var  logic [1:0] code,
    output var  logic       valid
);

    localparam int unsigned CW = $clog2(DIV) + 1;

    typedef enum logic {PH_UP, PH_DN} phase_e;

    phase_e          phase_q, phase_d;  // which pull is applied
    logic [CW-1:0]   cnt_q, cnt_d;      // settle divider
    logic            up_q, up_d;        // level seen under pull-up
    logic            pu_d, pd_d;
    logic [1:0]      code_d;
    logic            valid_d;
    logic            tick;

    // divider gives one enable pulse per settle interval
    assign tick = (cnt_q == '0);

    // next-state of the probe sequence
    always_comb begin
        phase_d = phase_q;
        cnt_d   = tick ? CW'(DIV - 1) : cnt_q - 1'b1;
        up_d    = up_q;
        code_d  = code;
        valid_d = valid;
        if (!enable) begin
            phase_d = PH_UP;           // restart probing when re-enabled
            cnt_d   = CW'(DIV);        // a full settle once the pull-up is back on
            valid_d = 1'b0;
        end else if (tick) begin
            case (phase_q)
                PH_UP: begin
                    up_d    = pin_i;
                    phase_d = PH_DN;
                end
                PH_DN: begin
                    code_d  = tri_code(up_q, pin_i);  // R05 R07 R14
                    valid_d = 1'b1;
                    phase_d = PH_UP;
                end
                default: phase_d = PH_UP;
            endcase
        end
        pu_d = enable && (phase_d == PH_UP);
        pd_d = enable && (phase_d == PH_DN);
    end

    // registers only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_q    <= PH_UP;
            cnt_q      <= CW'(DIV);  // first sample waits until the pull-up has settled
            up_q       <= 1'b0;
            pull_up_en <= 1'b0;
            pull_dn_en <= 1'b0;
            code       <= TRI_OPEN;
            valid      <= 1'b0;
        end else begin
            phase_q    <= phase_d;
            cnt_q      <= cnt_d;
            up_q       <= up_d;
            pull_up_en <= pu_d;
            pull_dn_en <= pd_d;
            code       <= code_d;
            valid      <= valid_d;
        end
    end

endmodule // tri_level_sense

`default_nettype wire

// File: verilog/general_purpose_pin_port.sv
// Purpose: general-purpose output, strap input and change-interrupt port
// Assumes: single 20 MHz clock, inputs synchronous except interrupt pins
// Notes:   registers reached over AHB-Lite, zero wait states
`default_nettype none

// Operation
// (R01) selected output pins drive programmed levels
// (R02) output levels hold through shutdown
// (R03) output level bits reset to one
// (R04) shared tenth pin: strap input or output
// (R05) tenth pin input reports ground, supply, open
// (R06) tenth pin output drives its level bit
// (R07) dedicated strap readable as three levels
// (R08) strap picks operating mode after reset
// (R09) interrupt inputs fire on both edges
// (R10) column five pin output by select bit
// (R11) two-bit field selects channel or outputs
// (R12) second interrupt input is hold control
// (R13) two-flop sync, sticky software-cleared flags
// (R14) codes: ground zero, supply one, open two
module general_purpose_pin_port import gp_port_pkg::*; #(
    parameter int unsigned TRI_DIV = TRI_SETTLE_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // chip state
    input  wire logic        shutdown,
    // channel port shared pins
    input  wire logic [3:0]  chan_func_i,
    output var  logic [3:0]  chan_pin_o,
    // column five / six shared pins
    input  wire logic [1:0]  col_pin_i,
    output var  logic [1:0]  col_pin_o,
    output var  logic [1:0]  col_pin_oe,
    output var  logic [1:0]  col_key_o,
    // shared tenth pin
    input  wire logic        tri0_i,
    output var  logic        tri0_o,
    output var  logic        tri0_oe,
    output var  logic        tri0_pu_en,
    output var  logic        tri0_pd_en,
    // dedicated strap pin
    input  wire logic        tri1_i,
    output var  logic        tri1_pu_en,
    output var  logic        tri1_pd_en,
    // external interrupt pins
    input  wire logic        ext_irq_zero,
    input  wire logic        ext_irq_one,
    input  wire logic        ext_irq_two,
    // status outputs
    output var  logic        hold_o,
    output var  logic [1:0]  op_mode,
    output var  logic        op_mode_valid,
    output var  logic        irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic        acc;                    // address phase taken
    logic        hit;                    // upper address bits zero
    logic        rd_stat;                // read of status, clears it
    logic        wr_pend_q, wr_pend_d;   // write data phase pending
    logic [7:0]  waddr_q, waddr_d;       // write offset held
    logic [31:0] rdata_d;
    logic [7:0]  lvl1_q, lvl1_d;         // gp_level_ctrl_first
    logic [7:0]  lvl2_q, lvl2_d;         // gp_level_ctrl_second
    logic [1:0]  csel_q, csel_d;         // channel_port_select
    logic [2:0]  mask_q, mask_d;         // interrupt mask
    logic [2:0]  stat_q, stat_d;         // sticky change flags
    logic [2:0]  sync1_q, sync2_q;       // interrupt synchroniser
    logic [2:0]  prev_q;                 // last synced level
    logic [2:0]  evt;                    // one-cycle change pulse
    logic [1:0]  mode_d;
    logic        mode_valid_d;
    logic [1:0]  tri0_code, tri1_code;
    logic        tri0_valid, tri1_valid;
    logic [2:0]  prime_q;                // chain filled since reset

    ////////////////////////////////////////////////////////////////////////
    // three-level detectors
    // pulls leave straight from the detector: an extra flop here would let
    // it sample the pin before the pull it asked for reached the pin
    tri_level_sense #(.DIV(TRI_DIV)) u_tri0 (
        .mclk       (mclk),
        .rstn       (rstn),
        .enable     (!lvl2_q[SEL_TRI0]),  // R04
        .pin_i      (tri0_i),
        .pull_up_en (tri0_pu_en),
        .pull_dn_en (tri0_pd_en),
        .code       (tri0_code),
        .valid      (tri0_valid)
    );

    tri_level_sense #(.DIV(TRI_DIV)) u_tri1 (
        .mclk       (mclk),
        .rstn       (rstn),
        .enable     (1'b1),
        .pin_i      (tri1_i),
        .pull_up_en (tri1_pu_en),
        .pull_dn_en (tri1_pd_en),
        .code       (tri1_code),
        .valid      (tri1_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode; every access is answered at once with okay
    assign acc     = hsel && htrans[1] && hready;
    assign hit     = (haddr[31:8] == 24'h0);
    assign rd_stat = acc && hit && !hwrite && (haddr[7:0] == OFF_IRQ_STAT);
    // no change is seen until the chain holds the pin, so a pin that is
    // high at reset release does not raise a false flag
    assign evt     = (sync2_q ^ prev_q) & {3{prime_q[2]}};  // R09

    // register file next values
    always_comb begin
        wr_pend_d = acc && hwrite && hit;
        waddr_d   = acc ? haddr[7:0] : waddr_q;
        lvl1_d    = lvl1_q;
        lvl2_d    = lvl2_q;
        csel_d    = csel_q;
        mask_d    = mask_q;
        // no writes land while shut down, so levels stay put
        if (wr_pend_q && !shutdown) begin  // R02
            case (waddr_q)
                OFF_LVL_FIRST:  lvl1_d = {hwdata[7:2], 2'b00};
                OFF_LVL_SECOND: lvl2_d = hwdata[7:0];
                OFF_CHAN_SEL:   csel_d = hwdata[CHAN_SEL_LSB +: 2];
                OFF_IRQ_MASK:   mask_d = hwdata[2:0];
                default: ;  // unmapped or read-only: ignored
            endcase
        end
        // change sets, read clears; set wins in the same cycle
        stat_d = (rd_stat ? 3'h0 : stat_q) | evt;  // R13
    end

    // read data, taken in the address phase from next values so that a
    // write just before a read is seen without a wait state
    always_comb begin
        rdata_d = hrdata;
        if (acc && !hwrite) begin
            rdata_d = 32'h0;  // unmapped reads as zero
            if (hit) begin
                case (haddr[7:0])
                    OFF_LVL_FIRST:  rdata_d[7:0] = lvl1_d;
                    OFF_LVL_SECOND: rdata_d[7:0] = lvl2_d;
                    OFF_CHAN_SEL:   rdata_d[CHAN_SEL_LSB +: 2] = csel_d;
                    OFF_TRI_STAT:   rdata_d[8:0] = {hold_o, 1'b0,
                                        op_mode_valid, op_mode,
                                        tri1_code, tri0_code};  // R05 R07
                    OFF_IRQ_STAT:   rdata_d[2:0] = stat_q;
                    OFF_IRQ_MASK:   rdata_d[2:0] = mask_d;
                    default: ;
                endcase
            end
        end
    end

    // strap catch: first complete detection after release fixes the mode
    always_comb begin
        mode_d       = op_mode;
        mode_valid_d = op_mode_valid;
        if (!op_mode_valid && tri1_valid) begin
            mode_d       = tri1_code;  // R08
            mode_valid_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and register flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q     <= 1'b0;
            waddr_q       <= 8'h00;
            hrdata        <= 32'h0;
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            lvl1_q        <= LVL_FIRST_RST;   // R03
            lvl2_q        <= LVL_SECOND_RST;  // R03
            csel_q        <= 2'h0;
            mask_q        <= 3'h0;
            stat_q        <= 3'h0;
            op_mode       <= TRI_OPEN;
            op_mode_valid <= 1'b0;
        end else begin
            wr_pend_q     <= wr_pend_d;
            waddr_q       <= waddr_d;
            hrdata        <= rdata_d;
            hreadyout     <= 1'b1;
            hresp         <= 1'b0;
            lvl1_q        <= lvl1_d;
            lvl2_q        <= lvl2_d;
            csel_q        <= csel_d;
            mask_q        <= mask_d;
            stat_q        <= stat_d;
            op_mode       <= mode_d;
            op_mode_valid <= mode_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pins: two-flop sync then edge compare on the second flop
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 3'h0;
            prime_q <= 3'h0;
            hold_o  <= 1'b0;
            irq     <= 1'b0;
        end else begin
            sync1_q <= {ext_irq_two, ext_irq_one, ext_irq_zero};  // R13
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            // shift in ones: bit two marks sync and compare flops filled
            prime_q <= {prime_q[1:0], 1'b1};
            hold_o  <= sync2_q[1];              // R12
            irq     <= |(stat_q & mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, all registered
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chan_pin_o <= 4'h0;
            col_pin_o  <= 2'h3;
            col_pin_oe <= 2'h0;
            col_key_o  <= 2'h3;
            tri0_o     <= 1'b1;
            tri0_oe    <= 1'b0;
        end else begin
            // channel functions pass through unless outputs are picked
            chan_pin_o <= (csel_q == CHAN_SEL_GPO) ?
                          lvl1_q[LVL_OUT2 +: 4] : chan_func_i;  // R01 R11
            col_pin_o  <= lvl1_q[7:6];                          // R01
            col_pin_oe <= {lvl2_q[SEL_COL6], lvl2_q[SEL_COL5]}; // R10
            // scanner sees idle-high columns while a pin is an output
            col_key_o  <= col_pin_i | col_pin_oe;
            tri0_o     <= lvl2_q[LVL_GENERAL_OUTPUT_TEN];                    // R06
            tri0_oe    <= lvl2_q[SEL_TRI0];                     // R04
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_chan_gpo_drive: assert property ( // R11
        csel_q == CHAN_SEL_GPO |=> chan_pin_o == $past(lvl1_q[5:2]))
        else $error("channel pins not driving output levels");
    a_level_hold_sd: assert property ( // R02
        shutdown |=> lvl1_q == $past(lvl1_q) && lvl2_q == $past(lvl2_q))
        else $error("output level changed in shutdown");
    a_tri0_out_mode: assert property ( // R06
        lvl2_q[SEL_TRI0] |=> tri0_oe && tri0_o == $past(lvl2_q[LVL_GENERAL_OUTPUT_TEN])
                             && !tri0_pu_en && !tri0_pd_en)
        else $error("tenth pin output mode wrong");
    a_tri0_sense_off: assert property ( // R04
        tri0_oe |-> !tri0_pu_en && !tri0_pd_en)
        else $error("tenth pin pulled while driven");
    a_col5_select: assert property ( // R10
        lvl2_q[SEL_COL5] |=> col_pin_oe[0] && col_pin_o[0] == $past(lvl1_q[6]))
        else $error("column five output not driven");
    a_change_sets_flag: assert property ( // R09
        $changed(ext_irq_zero) |-> ##3 stat_q[0])
        else $error("change on interrupt zero not flagged");
    a_read_clears_flag: assert property ( // R13
        rd_stat && evt == 3'h0 |=> stat_q == 3'h0)
        else $error("status read did not clear flags");
    a_irq_gating: assert property ( // R13
        ##1 irq == |($past(stat_q) & $past(mask_q)))
        else $error("interrupt output not gated by mask");
    a_mode_stays_put: assert property ( // R08
        op_mode_valid |=> op_mode_valid && $stable(op_mode))
        else $error("operating mode changed after capture");
    a_tri_code_legal: assert property ( // R14
        tri0_code != 2'h3 && tri1_code != 2'h3)
        else $error("illegal three-level code");
    a_hold_follows: assert property ( // R12
        ext_irq_one |-> ##3 hold_o)
        else $error("hold does not follow interrupt one");

    c_irq_raised:  cover property (!irq ##1 irq);
    c_tri0_open:   cover property (tri0_valid && tri0_code == TRI_OPEN);
    c_mode_caught: cover property (!op_mode_valid ##1 op_mode_valid);
    c_gpo_select:  cover property (csel_q == CHAN_SEL_GPO && !shutdown);
    c_tri0_driven: cover property (tri0_oe && !tri0_o);

endmodule // general_purpose_pin_port

`default_nettype wire

// File: sim/board_straps.sv
// Purpose: board model for the two three-level strap pins
// Assumes: wiring 0 = tied low, 1 = tied high, 2 = left open
// Notes:   an open line with no pull applied wanders every cycle
`default_nettype none

module board_straps (
    // clock for the wandering open line
    input  wire logic       mclk,
    // shared tenth pin: wiring and device drive
    input  wire logic [1:0] tri0_state,
    input  wire logic       tri0_o,
    input  wire logic       tri0_oe,
    input  wire logic       tri0_pu_en,
    input  wire logic       tri0_pd_en,
    output var  logic       tri0_pin,
    // dedicated strap pin
    input  wire logic [1:0] tri1_state,
    input  wire logic       tri1_pu_en,
    input  wire logic       tri1_pd_en,
    output var  logic       tri1_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    logic float_q = 1'b0;  // open line without pull: never a steady value

    ////////////////////////////////////////////////////////////////////////
    // open line pattern, so a sampled unknown cannot pass as a level
    always @(posedge mclk) begin
        float_q <= ~float_q;
    end

    // level seen on a pin for a given wiring and pull choice
    function automatic logic level(input logic [1:0] st, input logic pu,
                                   input logic pd, input logic fl);
        if (st == 2'h0) return 1'b0;  // tied low beats any weak pull
        if (st == 2'h1) return 1'b1;  // tied high beats any weak pull
        if (pu) return 1'b1;          // open: follows the pull
        if (pd) return 1'b0;
        return fl;
    endfunction

    // device drive wins on the tenth pin; the bench leaves it open then
    always_comb begin
        tri0_pin = tri0_oe ? tri0_o : level(tri0_state, tri0_pu_en, tri0_pd_en, float_q);
        tri1_pin = level(tri1_state, tri1_pu_en, tri1_pd_en, float_q);
    end
endmodule // board_straps

`default_nettype wire

// File: sim/general_purpose_pin_port_tb_top.sv
// Purpose: self-checking bench for the general-purpose pin port
// Assumes: settle count shortened to 2, zero-wait register bus
// Notes:   straps come from the board model, other pins from here
`default_nettype none

module general_purpose_pin_port_tb_top import gp_port_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned DIV = 2;  // short settle keeps the run brief
    `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

    logic        mclk = 1'b0;
    logic        rstn, hsel, hwrite, shutdown, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, col_pin_i, col_pin_o, col_pin_oe, col_key_o, op_mode;
    logic [1:0]  tri0_st, tri1_st;       // board wiring of the strap pins
    logic [2:0]  hsize, xirq;            // xirq: interrupt pins zero..two
    logic [3:0]  chan_func_i, chan_pin_o;
    logic        tri0_i, tri0_o, tri0_oe, tri0_pu, tri0_pd;
    logic        tri1_i, tri1_pu, tri1_pd, hold_o, op_mode_valid, irq;
    int          fails, n_compared;

    ////////////////////////////////////////////////////////////////////////
    // clock, column pins with pull-ups when released
    always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    assign col_pin_i = (col_pin_o & col_pin_oe) | ~col_pin_oe;

    general_purpose_pin_port #(.TRI_DIV(DIV)) DUT (
        .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .shutdown(shutdown),
        .chan_func_i(chan_func_i), .chan_pin_o(chan_pin_o), .col_pin_i(col_pin_i),
        .col_pin_o(col_pin_o), .col_pin_oe(col_pin_oe), .col_key_o(col_key_o),
        .tri0_i(tri0_i), .tri0_o(tri0_o), .tri0_oe(tri0_oe), .tri0_pu_en(tri0_pu),
        .tri0_pd_en(tri0_pd), .tri1_i(tri1_i), .tri1_pu_en(tri1_pu),
        .tri1_pd_en(tri1_pd), .ext_irq_zero(xirq[0]), .ext_irq_one(xirq[1]),
        .ext_irq_two(xirq[2]), .hold_o(hold_o), .op_mode(op_mode),
        .op_mode_valid(op_mode_valid), .irq(irq));

    board_straps BOARD (
        .mclk(mclk), .tri0_state(tri0_st), .tri0_o(tri0_o), .tri0_oe(tri0_oe),
        .tri0_pu_en(tri0_pu), .tri0_pd_en(tri0_pd), .tri0_pin(tri0_i),
        .tri1_state(tri1_st), .tri1_pu_en(tri1_pu), .tri1_pd_en(tri1_pd),
        .tri1_pin(tri1_i));

    ////////////////////////////////////////////////////////////////////////
    // bus and timing helpers; every task is entered just after an edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one single word transfer; read data lands in rd
    task automatic bus(input int wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= (wr != 0);
        htrans <= 2'b10;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask

    // reset with a given strap wiring, then let the strap sense settle
    task automatic do_reset(input logic [1:0] strap);
        tri1_st <= strap;
        rstn <= 1'b0;
        cyc(4);
        rstn <= 1'b1;
        cyc(4 * DIV + 8);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values(input logic [1:0] mode);
        `CHK(col_pin_o, 2'b11)
        `CHK(tri0_o, 1'b1)
        `CHK({op_mode_valid, op_mode}, {1'b1, mode})
        bus(0, OFF_LVL_FIRST, 32'h0);
        `CHK(rd, 32'h0000_00fc)
        bus(1, 8'h40, 32'h0);           // unmapped write must land nowhere
        bus(0, OFF_LVL_SECOND, 32'h0);
        `CHK(rd, 32'h0000_0001)
        bus(0, OFF_IRQ_STAT, 32'h0);    // a pin left high over reset is no change
        `CHK(rd, 32'h0)
    endtask

    task automatic t_outputs();
        chan_func_i <= 4'ha;
        bus(1, OFF_LVL_FIRST, 32'h54);  // general_outputs_two_to_seven = 1,0,1,0,1,0
        bus(1, OFF_LVL_SECOND, 32'h61); // both column pins as outputs
        for (int s = 0; s < 4; s++) begin
            bus(1, OFF_CHAN_SEL, 32'((s + 2) % 4) << CHAN_SEL_LSB);
            cyc(2);
            `CHK(chan_pin_o, ((s + 2) % 4 == 1) ? 4'h5 : 4'ha)
        end
        `CHK(col_pin_oe, 2'b11)
        `CHK(col_pin_o, 2'b01)
        `CHK(col_key_o, 2'b11)
    endtask

    // writes during shutdown must not move any output
    task automatic t_shutdown();
        shutdown <= 1'b1;
        bus(1, OFF_LVL_FIRST, 32'hfc);
        cyc(2);
        `CHK({col_pin_o, chan_pin_o}, 6'h15)
        shutdown <= 1'b0;
        bus(1, OFF_LVL_FIRST, 32'hfc);
        cyc(2);
        `CHK({col_pin_o, chan_pin_o}, 6'h3f)
    endtask

    // both three-level pins through all wirings, then tenth pin as output
    task automatic t_three_level();
        for (int s = 0; s < 3; s++) begin
            tri0_st <= 2'(s);
            tri1_st <= 2'(2 - s);
            cyc(4 * DIV + 8);
            bus(0, OFF_TRI_STAT, 32'h0);
            `CHK(rd[1:0], 2'(s))
            `CHK(rd[3:2], 2'(2 - s))
            `CHK(op_mode, 2'h1)
        end
        bus(1, OFF_LVL_SECOND, 32'h80); // tenth pin drives low
        cyc(2);
        `CHK({tri0_oe, tri0_o, tri0_i, tri0_pu, tri0_pd}, 5'h10)
        bus(1, OFF_LVL_SECOND, 32'h81);
        cyc(2);
        `CHK({tri0_oe, tri0_o}, 2'b11)
    endtask

    // each pin rises then falls; status is sticky until read
    task automatic t_irq();
        bus(1, OFF_IRQ_MASK, 32'h7);
        for (int i = 0; i < 6; i++) begin
            xirq <= xirq ^ (3'h1 << (i % 3));
            cyc(6);
            `CHK(irq, 1'b1)
            bus(0, OFF_IRQ_STAT, 32'h0);
            `CHK(rd, 32'(1 << (i % 3)))
            cyc(2);
            `CHK(irq, 1'b0)
            `CHK(hold_o, xirq[1])
        end
        bus(1, OFF_IRQ_MASK, 32'h0);    // masked: flag set, line quiet
        xirq <= xirq ^ 3'h4;
        cyc(6);
        `CHK(irq, 1'b0)
        bus(0, OFF_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h4)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        shutdown = 1'b0;
        chan_func_i = 4'h0;
        xirq = 3'h0;
        tri0_st = 2'h2;
        tri1_st = 2'h1;
        fails = 0;
        n_compared = 0;
        do_reset(2'h1);
        t_reset_values(2'h1);
        t_outputs();
        t_shutdown();
        t_three_level();
        t_irq();
        bus(1, OFF_LVL_FIRST, 32'h0);   // levels low, then reset in mid-run
        do_reset(2'h2);
        t_reset_values(2'h2);
        give_verdict();
    end

    // a hang counts as a mismatch
    initial begin
        cyc(5000);
        fails++;
        give_verdict();
    end

    `undef CHK
endmodule // general_purpose_pin_port_tb_top

`default_nettype wire
